// >>> design/tcc_pkg.sv
// Package of constants and types for the 8-bit timer/counter core
package tcc_pkg;
	// ************************************************************
	// Register offsets (APB byte addresses)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL_A  = 8'h00;
	localparam logic [7:0] OFS_CTRL_B  = 8'h04;
	localparam logic [7:0] OFS_CTRL_C  = 8'h08;
	localparam logic [7:0] OFS_COUNT   = 8'h0c;
	localparam logic [7:0] OFS_CMP_A   = 8'h10;
	localparam logic [7:0] OFS_CMP_B   = 8'h14;
	localparam logic [7:0] OFS_MASK    = 8'h18;
	localparam logic [7:0] OFS_FLAG    = 8'h1c;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CA_WAVEFORM_MODE_SELECT   = 0;
	localparam int CA_WGM1   = 1;
	localparam int CA_COMB   = 4;
	localparam int CA_COMA   = 6;
	localparam int CB_CS     = 0;
	localparam int CB_WGM2   = 3;
	localparam int CC_FOCB   = 6;
	localparam int CC_FOCA   = 7;
	localparam int FL_OVF    = 0;
	localparam int FL_CMPA   = 1;
	localparam int FL_CMPB   = 2;

	// ************************************************************
	// Values
	// ************************************************************
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;
	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [1:0] COM_NONE   = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	// Waveform modes
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PC_MAX = 3'h1;
	localparam logic [2:0] WGM_CTC    = 3'h2;
	localparam logic [2:0] WGM_FP_MAX = 3'h3;
	localparam logic [2:0] WGM_PC_OCA = 3'h5;
	localparam logic [2:0] WGM_FP_OCA = 3'h7;

	typedef enum logic [1:0] {
		TCC_UP,
		TCC_DOWN
	} tcc_dir_t;
endpackage : tcc_pkg

// >>> design/tcc_tick_gen.sv
// Timer tick source: prescaler and external count pin edge detect
`timescale 1ns/100ps
module tcc_tick_gen #(
	parameter int PRE_W = 10
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	// Control
	input  wire logic [2:0] clock_source_select,
	input  wire logic       external_count_pin,
	// Tick
	output logic            timer_tick
);
	// ************************************************************
	// Prescaler and pin edge detect
	// ************************************************************
	logic [PRE_W-1:0] pre_r;
	logic             pin_d_r;
	wire              rise = external_count_pin & ~pin_d_r;
	wire              fall = ~external_count_pin & pin_d_r;
	wire              stop = (clock_source_select == tcc_pkg::CS_STOP);

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_r   <= '0;
			pin_d_r <= 1'b0;
		end
		else if (clk_en)
		begin
			pre_r   <= stop ? '0 : pre_r + 1'b1;
			pin_d_r <= external_count_pin;
		end
	end

	// Prescaled wrap at 8, 64, 256, 1024
	wire w8    = (pre_r[2:0] == 3'h7);
	wire w64   = (pre_r[5:0] == 6'h3f);
	wire w256  = (pre_r[7:0] == 8'hff);
	wire w1024 = (pre_r[9:0] == 10'h3ff);

	always_comb
	begin
		case (clock_source_select)
			tcc_pkg::CS_STOP:     timer_tick = 1'b0;
			tcc_pkg::CS_DIV1:     timer_tick = 1'b1;
			tcc_pkg::CS_DIV8:     timer_tick = w8;
			tcc_pkg::CS_DIV64:    timer_tick = w64;
			tcc_pkg::CS_DIV256:   timer_tick = w256;
			tcc_pkg::CS_DIV1024:  timer_tick = w1024;
			tcc_pkg::CS_EXT_FALL: timer_tick = fall;
			default:              timer_tick = rise;
		endcase
	end
endmodule : tcc_tick_gen

// >>> design/tcc_cmp_unit.sv
// One output compare unit: buffer, match flag raise, output state
`timescale 1ns/100ps
module tcc_cmp_unit (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	// CPU side
	input  wire logic       wr_val,
	input  wire logic [7:0] wdata,
	input  wire logic       force_compare_strobe,
	input  wire logic [1:0] compare_output_mode,
	// Counter side
	input  wire logic [7:0] count,
	input  wire logic       timer_tick,
	input  wire logic       block,
	input  wire logic       pwm,
	input  wire logic       fast,
	input  wire logic       load_pt,
	input  wire logic       at_bottom,
	input  wire logic       down,
	// Results
	output logic [7:0]      buf_val,
	output logic [7:0]      act_val,
	output logic            match_evt,
	output logic            out_state
);
	// ************************************************************
	// Buffer, active value, output state
	// ************************************************************
	logic [7:0] buf_r;
	logic [7:0] act_r;
	logic       oc_r;
	logic       oc_nxt;
	wire        eq     = (count == act_r);
	assign match_evt   = eq & timer_tick & ~block;
	assign buf_val     = buf_r;
	assign act_val     = act_r;
	assign out_state   = oc_r;

	always_comb
	begin
		oc_nxt = oc_r;
		if (!pwm)
		begin
			if (match_evt | force_compare_strobe)
			begin
				case (compare_output_mode)
					tcc_pkg::COM_TOGGLE: oc_nxt = ~oc_r;
					tcc_pkg::COM_CLEAR:  oc_nxt = 1'b0;
					tcc_pkg::COM_SET:    oc_nxt = 1'b1;
					default:             oc_nxt = oc_r;
				endcase
			end
		end
		else if (compare_output_mode[1])
		begin
			if (fast & at_bottom & timer_tick)
				oc_nxt = ~compare_output_mode[0];
			if (match_evt)
				oc_nxt = compare_output_mode[0] ^ (~fast & down);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			buf_r <= tcc_pkg::REG_RESET;
			act_r <= tcc_pkg::REG_RESET;
			oc_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_val)
				buf_r <= wdata;
			if (!pwm)
				act_r <= wr_val ? wdata : buf_r;
			else if (load_pt & timer_tick)
				act_r <= buf_r;
			oc_r <= oc_nxt;
		end
	end
endmodule : tcc_cmp_unit

// >>> design/tcc_timer8.sv
// Top of the 8-bit timer/counter core with APB register access
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module tcc_timer8 #(
	parameter int PRE_W = 10
) (
	// Clock, enable, reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Interrupt service acknowledges
	input  wire logic        irq_ack_ovf,
	input  wire logic        irq_ack_cmpa,
	input  wire logic        irq_ack_cmpb,
	// Pins and requests
	input  wire logic        external_count_pin,
	output logic             compare_output_a,
	output logic             compare_output_b,
	output logic [2:0]       irq_req
);
	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] ctrl_a_r;
	logic [3:0] ctrl_b_r;
	logic [7:0] timer_count_value_r;
	logic [7:0] count_nxt;
	logic [2:0] timer_mask_register_r;
	logic [2:0] timer_flag_register_r;
	logic [2:0] flag_nxt;
	tcc_pkg::tcc_dir_t dir_r;
	tcc_pkg::tcc_dir_t dir_nxt;
	logic       block_r;
	logic       pready_r;
	logic       pslverr_r;
	logic [31:0] prdata_r;
	logic       oca_r;
	logic       ocb_r;
	logic [2:0] irq_r;

	// ************************************************************
	// Bus decode
	// ************************************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	wire acc      = psel & penable & ~pready_r;
	wire wr       = acc & pwrite;
	wire rd       = acc & ~pwrite;
	wire wr_ca    = wr & hit(paddr, tcc_pkg::OFS_CTRL_A);
	wire wr_cb    = wr & hit(paddr, tcc_pkg::OFS_CTRL_B);
	wire wr_cc    = wr & hit(paddr, tcc_pkg::OFS_CTRL_C);
	wire wr_cnt   = wr & hit(paddr, tcc_pkg::OFS_COUNT);
	wire wr_oa    = wr & hit(paddr, tcc_pkg::OFS_CMP_A);
	wire wr_ob    = wr & hit(paddr, tcc_pkg::OFS_CMP_B);
	wire wr_msk   = wr & hit(paddr, tcc_pkg::OFS_MASK);
	wire wr_flg   = wr & hit(paddr, tcc_pkg::OFS_FLAG);
	wire mapped   = hit(paddr, tcc_pkg::OFS_CTRL_A)
		| hit(paddr, tcc_pkg::OFS_CTRL_B) | hit(paddr, tcc_pkg::OFS_CTRL_C)
		| hit(paddr, tcc_pkg::OFS_COUNT) | hit(paddr, tcc_pkg::OFS_CMP_A)
		| hit(paddr, tcc_pkg::OFS_CMP_B) | hit(paddr, tcc_pkg::OFS_MASK)
		| hit(paddr, tcc_pkg::OFS_FLAG);

	// ************************************************************
	// Mode decode
	// ************************************************************
	wire [2:0] waveform_mode_select = {ctrl_b_r[tcc_pkg::CB_WGM2],
		ctrl_a_r[tcc_pkg::CA_WGM1], ctrl_a_r[tcc_pkg::CA_WAVEFORM_MODE_SELECT]};
	wire [2:0] clock_source_select  = ctrl_b_r[tcc_pkg::CB_CS +: 3];
	wire [1:0] com_a = ctrl_a_r[tcc_pkg::CA_COMA +: 2];
	wire [1:0] com_b = ctrl_a_r[tcc_pkg::CA_COMB +: 2];
	wire ctc   = (waveform_mode_select == tcc_pkg::WGM_CTC);
	wire fast  = (waveform_mode_select == tcc_pkg::WGM_FP_MAX)
		| (waveform_mode_select == tcc_pkg::WGM_FP_OCA);
	wire pc    = (waveform_mode_select == tcc_pkg::WGM_PC_MAX)
		| (waveform_mode_select == tcc_pkg::WGM_PC_OCA);
	wire pwm   = fast | pc;
	wire top_a = (waveform_mode_select == tcc_pkg::WGM_FP_OCA)
		| (waveform_mode_select == tcc_pkg::WGM_PC_OCA);

	// ************************************************************
	// Counter unit
	// ************************************************************
	logic       timer_tick;
	logic [7:0] act_a;
	logic [7:0] act_b;
	logic [7:0] buf_a;
	logic [7:0] buf_b;
	logic       match_a;
	logic       match_b;
	logic       st_a;
	logic       st_b;
	wire at_bottom = (timer_count_value_r == tcc_pkg::CNT_BOTTOM);
	wire at_max    = (timer_count_value_r == tcc_pkg::CNT_MAX);
	wire [7:0] top_val = (top_a | ctc) ? act_a : tcc_pkg::CNT_MAX;
	wire at_top    = (timer_count_value_r == top_val);
	wire is_down   = (dir_r == tcc_pkg::TCC_DOWN);
	wire load_pt   = fast ? at_top : at_top;
	wire [7:0] inc = timer_count_value_r + 8'h01;
	wire [7:0] dec = timer_count_value_r - 8'h01;

	always_comb
	begin
		count_nxt = timer_count_value_r;
		dir_nxt   = dir_r;
		if (timer_tick)
		begin
			if (pc)
			begin
				if (at_top & ~is_down)
					dir_nxt = tcc_pkg::TCC_DOWN;
				else if (at_bottom & is_down)
					dir_nxt = tcc_pkg::TCC_UP;
				count_nxt = (dir_nxt == tcc_pkg::TCC_DOWN) ? dec : inc;
			end
			else if ((ctc | fast) & at_top)
			begin
				count_nxt = tcc_pkg::CNT_BOTTOM;
				dir_nxt   = tcc_pkg::TCC_UP;
			end
			else
			begin
				count_nxt = inc;
				dir_nxt   = tcc_pkg::TCC_UP;
			end
		end
		if (wr_cnt)
			count_nxt = pwdata[7:0];
	end

	// Overflow at count maximum, at top in fast PWM with top at compare A, or at bottom in phase correct
	wire ovf_evt = timer_tick & (pc ? (at_bottom & is_down)
		: (fast & top_a) ? at_top : at_max);

	always_comb
	begin
		flag_nxt = timer_flag_register_r;
		if (wr_flg)
			flag_nxt = flag_nxt & ~pwdata[2:0];
		if (irq_ack_ovf)
			flag_nxt[tcc_pkg::FL_OVF] = 1'b0;
		if (irq_ack_cmpa)
			flag_nxt[tcc_pkg::FL_CMPA] = 1'b0;
		if (irq_ack_cmpb)
			flag_nxt[tcc_pkg::FL_CMPB] = 1'b0;
		if (ovf_evt)
			flag_nxt[tcc_pkg::FL_OVF] = 1'b1;
		if (match_a)
			flag_nxt[tcc_pkg::FL_CMPA] = 1'b1;
		if (match_b)
			flag_nxt[tcc_pkg::FL_CMPB] = 1'b1;
	end

	// ************************************************************
	// Read mux
	// ************************************************************
	wire [7:0] rd_byte =
		hit(paddr, tcc_pkg::OFS_CTRL_A) ? ctrl_a_r :
		hit(paddr, tcc_pkg::OFS_CTRL_B) ? {4'h0, ctrl_b_r} :
		hit(paddr, tcc_pkg::OFS_COUNT)  ? timer_count_value_r :
		hit(paddr, tcc_pkg::OFS_CMP_A)  ? (pwm ? buf_a : act_a) :
		hit(paddr, tcc_pkg::OFS_CMP_B)  ? (pwm ? buf_b : act_b) :
		hit(paddr, tcc_pkg::OFS_MASK)   ? {5'h00, timer_mask_register_r} :
		hit(paddr, tcc_pkg::OFS_FLAG)   ? {5'h00, timer_flag_register_r} :
		8'h00;

	// ************************************************************
	// Sequential state
	// ************************************************************
	// APB response
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready_r  <= acc;
			pslverr_r <= acc & ~mapped;
			if (rd)
				prdata_r <= {24'h00_0000, rd_byte};
		end
	end

	// Control and mask registers
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_a_r              <= tcc_pkg::REG_RESET;
			ctrl_b_r              <= 4'h0;
			timer_mask_register_r <= 3'h0;
		end
		else if (clk_en)
		begin
			if (wr_ca)
				ctrl_a_r <= pwdata[7:0];
			if (wr_cb)
				ctrl_b_r <= pwdata[3:0];
			if (wr_msk)
				timer_mask_register_r <= pwdata[2:0];
		end
	end

	// Counter, direction and match blocking
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_count_value_r <= tcc_pkg::REG_RESET;
			dir_r               <= tcc_pkg::TCC_UP;
			block_r             <= 1'b0;
		end
		else if (clk_en)
		begin
			timer_count_value_r <= count_nxt;
			dir_r               <= dir_nxt;
			if (wr_cnt)
				block_r <= 1'b1;
			else if (timer_tick)
				block_r <= 1'b0;
		end
	end

	// Flags, requests and compare outputs
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_flag_register_r <= 3'h0;
			irq_r                 <= 3'h0;
			oca_r                 <= 1'b0;
			ocb_r                 <= 1'b0;
		end
		else if (clk_en)
		begin
			timer_flag_register_r <= flag_nxt;
			irq_r <= flag_nxt & timer_mask_register_r;
			oca_r                 <= st_a;
			ocb_r                 <= st_b;
		end
	end

	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign prdata           = prdata_r;
	assign compare_output_a = oca_r;
	assign compare_output_b = ocb_r;
	assign irq_req          = irq_r;

	// ************************************************************
	// Sub units
	// ************************************************************
	tcc_tick_gen #(.PRE_W(PRE_W)) u_tick (
		.clk_sys             (clk_sys),
		.resetn              (resetn),
		.clk_en              (clk_en),
		.clock_source_select (clock_source_select),
		.external_count_pin  (external_count_pin),
		.timer_tick          (timer_tick)
	);

	tcc_cmp_unit u_cmp_a (
		.clk_sys              (clk_sys),
		.resetn               (resetn),
		.clk_en               (clk_en),
		.wr_val               (wr_oa),
		.wdata                (pwdata[7:0]),
		.force_compare_strobe (wr_cc & pwdata[tcc_pkg::CC_FOCA] & ~pwm),
		.compare_output_mode  (com_a),
		.count                (timer_count_value_r),
		.timer_tick           (timer_tick),
		.block                (block_r),
		.pwm                  (pwm),
		.fast                 (fast),
		.load_pt              (load_pt),
		.at_bottom            (at_bottom),
		.down                 (is_down),
		.buf_val              (buf_a),
		.act_val              (act_a),
		.match_evt            (match_a),
		.out_state            (st_a)
	);

	tcc_cmp_unit u_cmp_b (
		.clk_sys              (clk_sys),
		.resetn               (resetn),
		.clk_en               (clk_en),
		.wr_val               (wr_ob),
		.wdata                (pwdata[7:0]),
		.force_compare_strobe (wr_cc & pwdata[tcc_pkg::CC_FOCB] & ~pwm),
		.compare_output_mode  (com_b),
		.count                (timer_count_value_r),
		.timer_tick           (timer_tick),
		.block                (block_r),
		.pwm                  (pwm),
		.fast                 (fast),
		.load_pt              (load_pt),
		.at_bottom            (at_bottom),
		.down                 (is_down),
		.buf_val              (buf_b),
		.act_val              (act_b),
		.match_evt            (match_b),
		.out_state            (st_b)
	);
endmodule : tcc_timer8

// >>> tb/tcc_cpu_model.sv
// CPU model: APB master and interrupt service strobes
`timescale 1ns/100ps
module tcc_cpu_model (
	// Clock
	input  wire logic        clk_sys,
	// APB master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	// Interrupt service
	output logic [2:0]       irq_ack
);
	int hang = 0;
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, irq_ack} = '0;
	end
	// One transfer, held until pready is sampled high or 20 cycles pass
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n == 20)
			hang++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// Service strobe of one request
	task automatic service(input int b);
		@(posedge clk_sys);
		irq_ack[b] <= 1'b1;
		@(posedge clk_sys);
		irq_ack[b] <= 1'b0;
	endtask : service
endmodule : tcc_cpu_model

// >>> tb/tcc_timer8_props.sv
// Port checker of the timer core
`timescale 1ns/100ps
module tcc_timer8_props (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	// Service and outputs
	input  wire logic        irq_ack_ovf,
	input  wire logic        irq_ack_cmpa,
	input  wire logic        compare_output_a,
	input  wire logic        compare_output_b,
	input  wire logic [2:0]  irq_req
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	a_ready_follows: assert property (
		psel && penable && !pready && clk_en |=> pready)
		else $error("No pready after access");
	a_ready_single: assert property (pready && clk_en |=> !pready)
		else $error("pready longer than one cycle");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_error_zero: assert property (pslverr && !pwrite |-> prdata == '0)
		else $error("Refused read not zero");
	a_data_width: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("Read data above eight bits");
	a_reset_quiet: assert property ($rose(resetn) |-> irq_req == 3'h0 &&
		!compare_output_a && !compare_output_b)
		else $error("Outputs not cleared by reset");
	a_ack_ovf: assert property (irq_ack_ovf && clk_en ##1 clk_en
		|=> !irq_req[0])
		else $error("Overflow request kept after service");
	a_ack_cmpa: assert property (irq_ack_cmpa && clk_en ##1 clk_en
		|=> !irq_req[1])
		else $error("Compare A request kept after service");
	a_freeze_out: assert property (!clk_en |=> $stable(irq_req) &&
		$stable(compare_output_a) && $stable(compare_output_b))
		else $error("Outputs moved while frozen");
endmodule : tcc_timer8_props

bind tcc_timer8 tcc_timer8_props u_props (.clk_sys, .resetn, .clk_en, .psel,
	.penable, .pwrite, .pready, .prdata, .pslverr, .irq_ack_ovf,
	.irq_ack_cmpa, .compare_output_a, .compare_output_b, .irq_req);

// >>> tb/tb.sv
// Self-checking testbench of the timer core
`timescale 1ns/100ps
module tb;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        clk_en = 1'b1;
	logic        external_count_pin = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic        compare_output_a, compare_output_b;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  irq_ack, irq_req;
	int          fails = 0;
	int          total_checks = 0;
	int          n;
	logic [7:0]  regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c};
	logic [1:0]  com_seq [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1};
	logic        out_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	tcc_cpu_model cpu (.clk_sys(clk_sys), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .irq_ack(irq_ack));
	tcc_timer8 #(.PRE_W(10)) DUT (.clk_sys(clk_sys), .resetn(resetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .irq_ack_ovf(irq_ack[0]),
		.irq_ack_cmpa(irq_ack[1]), .irq_ack_cmpb(irq_ack[2]),
		.external_count_pin(external_count_pin),
		.compare_output_a(compare_output_a),
		.compare_output_b(compare_output_b), .irq_req(irq_req));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cpu.xfer(w, a, d, q, e);
		if (cpu.hang != 0)
		begin
			fails++;
			$display("[ERR] %0t bus transfer timed out", $time);
			give_verdict();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask : rd
	task automatic setup(input logic [2:0] wgm, input logic [2:0] cs,
		input logic [1:0] com);
		bus(1'b1, tcc_pkg::OFS_CTRL_A, {24'h0, com, com, 2'h0, wgm[1:0]});
		bus(1'b1, tcc_pkg::OFS_CTRL_B, {28'h0, wgm[2], cs});
	endtask : setup
	task automatic wait_irq(input int b);
		for (n = 0; n < 400 && irq_req[b] !== 1'b1; n++)
			@(posedge clk_sys);
		if (n == 400)
		begin
			fails++;
			$display("[ERR] %0t request %0d never raised", $time, b);
			give_verdict();
		end
	endtask : wait_irq
	task automatic outs(input logic [1:0] exp);
		@(posedge clk_sys);
		check({30'h0, compare_output_a, compare_output_b}, {30'h0, exp});
	endtask : outs
	task automatic watch(input int cnt, input int skip, input logic [7:0] lim);
		for (int i = 0; i < cnt; i++)
		begin
			bus(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
			if (i >= skip)
				check({31'h0, q[7:0] > lim}, 32'h0);
		end
	endtask : watch
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		foreach (regs[i]) rd(regs[i], 32'h0);
		bus(1'b1, 8'h20, 32'h5);
		check({31'h0, e}, 32'h1);
		bus(1'b0, 8'h20, 32'h0);
		check({30'h0, e, q == 32'h0}, 32'h3);
		bus(1'b1, tcc_pkg::OFS_CMP_A, 32'h1234565a);
		rd(tcc_pkg::OFS_CMP_A, 32'h5a);
		bus(1'b1, tcc_pkg::OFS_CMP_B, 32'hffffffa5);
		rd(tcc_pkg::OFS_CMP_B, 32'ha5);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h33);
		repeat (10) @(posedge clk_sys);
		rd(tcc_pkg::OFS_COUNT, 32'h33);
		// Overflow in normal mode, with a freeze
		bus(1'b1, tcc_pkg::OFS_MASK, 32'h1);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'hf0);
		setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_DIV1, 2'h0);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		repeat (5) @(posedge clk_sys);
		clk_en <= 1'b1;
		wait_irq(0);
		setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, 2'h0);
		rd(tcc_pkg::OFS_FLAG, 32'h1);
		check({29'h0, irq_req}, 32'h1);
		cpu.service(0);
		rd(tcc_pkg::OFS_FLAG, 32'h0);
		// Clear on compare A
		bus(1'b1, tcc_pkg::OFS_MASK, 32'h2);
		bus(1'b1, tcc_pkg::OFS_CMP_A, 32'h9);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h0);
		setup(tcc_pkg::WGM_CTC, tcc_pkg::CS_DIV1, 2'h0);
		watch(20, 0, 8'h09);
		wait_irq(1);
		setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, 2'h0);
		rd(tcc_pkg::OFS_FLAG, 32'h2);
		check({29'h0, irq_req}, 32'h2);
		bus(1'b1, tcc_pkg::OFS_FLAG, 32'h2);
		rd(tcc_pkg::OFS_FLAG, 32'h0);
		// Counter write blocks the first match
		bus(1'b1, tcc_pkg::OFS_CMP_A, 32'h50);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h50);
		setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_DIV1, 2'h0);
		setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, 2'h0);
		rd(tcc_pkg::OFS_FLAG, 32'h0);
		// Forced compare per output mode
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h77);
		for (int i = 0; i < 5; i++)
		begin
			setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, com_seq[i]);
			bus(1'b1, tcc_pkg::OFS_CTRL_C, 32'hc0);
			outs({2{out_exp[i]}});
		end
		rd(tcc_pkg::OFS_FLAG, 32'h0);
		rd(tcc_pkg::OFS_COUNT, 32'h77);
		setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, tcc_pkg::COM_SET);
		bus(1'b1, tcc_pkg::OFS_CTRL_C, 32'hc0);
		outs(2'h3);
		setup(tcc_pkg::WGM_FP_MAX, tcc_pkg::CS_STOP, tcc_pkg::COM_TOGGLE);
		outs(2'h3);
		bus(1'b1, tcc_pkg::OFS_CTRL_C, 32'hc0);
		outs(2'h3);
		// Buffered compare A in fast PWM with top at maximum
		bus(1'b1, tcc_pkg::OFS_CMP_A, 32'h10);
		rd(tcc_pkg::OFS_CMP_A, 32'h10);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h20);
		setup(tcc_pkg::WGM_FP_MAX, tcc_pkg::CS_DIV1, 2'h0);
		for (n = 0; n < 60 && q[7:0] < 8'h60; n++)
			bus(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
		check({31'h0, n == 60}, 32'h0);
		setup(tcc_pkg::WGM_FP_MAX, tcc_pkg::CS_STOP, 2'h0);
		rd(tcc_pkg::OFS_FLAG, 32'h2);
		cpu.service(1);
		rd(tcc_pkg::OFS_FLAG, 32'h0);
		// Fast PWM with top at compare A, new top loaded at top
		setup(tcc_pkg::WGM_FP_OCA, tcc_pkg::CS_STOP, 2'h0);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h0);
		bus(1'b1, tcc_pkg::OFS_CMP_A, 32'h30);
		setup(tcc_pkg::WGM_FP_OCA, tcc_pkg::CS_DIV1, 2'h0);
		watch(90, 40, 8'h30);
		// External pin, falling then rising edge
		for (int c = 6; c < 8; c++)
		begin
			setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, 2'h0);
			bus(1'b1, tcc_pkg::OFS_COUNT, 32'h0);
			setup(tcc_pkg::WGM_NORMAL, 3'(c), 2'h0);
			repeat (4)
			begin
				@(posedge clk_sys);
				external_count_pin <= 1'b1;
				repeat (4) @(posedge clk_sys);
				external_count_pin <= 1'b0;
				repeat (4) @(posedge clk_sys);
			end
			setup(tcc_pkg::WGM_NORMAL, tcc_pkg::CS_STOP, 2'h0);
			rd(tcc_pkg::OFS_COUNT, 32'h4);
		end
		// Compare B flag, request and service
		bus(1'b1, tcc_pkg::OFS_FLAG, 32'h7);
		bus(1'b1, tcc_pkg::OFS_MASK, 32'h4);
		bus(1'b1, tcc_pkg::OFS_CMP_B, 32'h8);
		bus(1'b1, tcc_pkg::OFS_COUNT, 32'h0);
		bus(1'b1, tcc_pkg::OFS_CTRL_B, 32'h1);
		wait_irq(2);
		bus(1'b1, tcc_pkg::OFS_CTRL_B, 32'h0);
		rd(tcc_pkg::OFS_FLAG, 32'h4);
		cpu.service(2);
		rd(tcc_pkg::OFS_FLAG, 32'h0);
		// Reset in mid-run clears outputs and state
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		outs(2'h0);
		rd(tcc_pkg::OFS_COUNT, 32'h0);
		rd(tcc_pkg::OFS_CTRL_B, 32'h0);
		give_verdict();
	end
endmodule : tb
